// ### logic/pll_regs.svh
`ifndef PLL_REGS_SVH
`define PLL_REGS_SVH
`define VCO_PREDIV        8'h04
`define OUTDIV_MIN        7'h01
`define OUTDIV_MAX        7'h7F
`define FEEDBACK_DIVIDER_EXT_MIN     11'h001
`define FEEDBACK_DIVIDER_EXT_MAX     11'h4E2
`define FRACTIONAL_FEEDBACK_FIELD_W            24
`define SPREAD_MAX        5'h1F
`define DEPTH_STEP_PPM    16'h03E8
`define PPM_FULL          32'h000F4240
`define LFSR_SEED         16'hACE1
`define SYNC_RESET_VAL    3'h0
`endif

// ### logic/pll_pkg.sv
package pll_pkg;
    typedef enum logic [2:0]
    {
        FB_POST_VCO = 3'h1,
        FB_POST_DIV = 3'h2,
        FB_EXTERNAL = 3'h4
    } fb_mode_t;
    typedef enum logic [1:0]
    {
        SS_IDLE = 2'h1,
        SS_RUN  = 2'h2
    } ss_state_t;
endpackage

// ### logic/out_div_if.sv
interface out_div_if;
    logic       restart;
    logic       gate;
    logic [6:0] div;
    logic       tick;
    logic       clk_out;
    modport ctl (output restart, output gate, output div, input tick, input clk_out);
    modport dv  (input restart, input gate, input div, output tick, output clk_out);
endinterface

// ### logic/out_div.sv
`include "pll_regs.svh"
module out_div
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic step_i,
    out_div_if.dv     bus
);
    logic [6:0] cnt;
    logic [6:0] next_cnt;
    logic       level;
    logic       next_level;
    logic       tk;
    logic       next_tk;
    always_comb
    begin
        next_cnt   = cnt;
        next_level = level;
        next_tk    = 1'b0;
        if (bus.restart || !bus.gate)
        begin
            next_cnt   = 7'h00;
            next_level = 1'b0;
        end
        else if (step_i)
        begin
            if (cnt + 7'h01 >= bus.div)
            begin
                next_cnt   = 7'h00;
                next_level = ~level;
                next_tk    = 1'b1;
            end
            else
            begin
                next_cnt = cnt + 7'h01;
            end
        end
    end
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt   <= 7'h00;
            level <= 1'b0;
            tk    <= 1'b0;
        end
        else
        begin
            cnt   <= next_cnt;
            level <= next_level;
            tk    <= next_tk;
        end
    end
    assign bus.clk_out = level;
    assign bus.tick    = tk;
endmodule // out_div

// ### logic/pll_divider_and_spread_modulator.sv
`include "pll_regs.svh"
module pll_divider_and_spread_modulator
    import pll_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        lock_i,
    input  wire logic [2:0]  fb_mode_i,
    input  wire logic        fractional_feedback_field_mode_i,
    input  wire logic [5:0]  reference_divider_i,
    input  wire logic [10:0] feedback_divider_i,
    input  wire logic [23:0] fractional_feedback_field_i,
    input  wire logic [27:0] output_divider_i,
    input  wire logic        cascade_i,
    input  wire logic        ss_enable_i,
    input  wire logic        ss_down_i,
    input  wire logic        ss_noise_i,
    input  wire logic [4:0]  ss_spread_i,
    input  wire logic [15:0] ss_rate_i,
    input  wire logic        feedback_clock_input_i,
    output logic      [3:0]  clk_out_o,
    output logic      [11:0] fb_int_o,
    output logic      [23:0] fb_fractional_feedback_field_o,
    output logic             fb_carry_o,
    output logic             fb_sel_fbin_o,
    output logic             cfg_error_o,
    output logic             ss_active_o
);
    fb_mode_t   mode;
    assign mode = fb_mode_t'(fb_mode_i);

    // Pin inputs cross three stages; only the last two are compared
    logic [2:0] lock_s;
    logic [2:0] fbk_s;
    logic       lock;
    logic       next_lock;
    logic       lock_rise;
    logic       fbk;
    logic       next_fbk;
    always_comb
    begin
        next_lock = (lock_s[1] == lock_s[2]) ? lock_s[2] : lock;
        next_fbk  = (fbk_s[1] == fbk_s[2]) ? fbk_s[2] : fbk;
    end
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lock_s <= `SYNC_RESET_VAL;
            fbk_s  <= `SYNC_RESET_VAL;
            lock   <= 1'b0;
            fbk    <= 1'b0;
        end
        else
        begin
            lock_s <= {lock_s[1:0], lock_i};
            fbk_s  <= {fbk_s[1:0], feedback_clock_input_i};
            lock   <= next_lock;
            fbk    <= next_fbk;
        end
    end
    assign lock_rise = next_lock & ~lock;

    // Divide-by-four prescale: pre[1] is the oscillator over four
    // Dividers step on both of its edges, so odd dividers keep an even duty
    logic [1:0] pre;
    logic [1:0] next_pre;
    logic       step;
    assign next_pre = pre + 2'h1;
    assign step = pre[0];
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            pre <= 2'h0;
        else
            pre <= next_pre;
    end

    out_div_if od [4] ();
    logic [3:0] steps;
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_div
            logic [6:0] d;
            assign d = output_divider_i[g*7 +: 7];
            assign od[g].div = (d < `OUTDIV_MIN) ? `OUTDIV_MIN : d;
            assign od[g].restart = lock_rise;
            assign od[g].gate = lock;
            out_div u_div
            (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .step_i (steps[g]),
                .bus    (od[g])
            );
        end
    endgenerate
    // Cascade: fourth divider counts third's ticks
    // A tick marks every edge of the third output, so the pair divides as a product
    assign steps[2:0] = {3{step}};
    assign steps[3] = cascade_i ? od[2].tick : step;

    logic [3:0] next_clk;
    assign next_clk = lock ? {od[3].clk_out, od[2].clk_out, od[1].clk_out, od[0].clk_out}
                           : 4'h0;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            clk_out_o <= 4'h0;
        else
            clk_out_o <= next_clk;
    end

    // Spread modulator: triangle or LFSR offset in ppm-scaled fraction units
    ss_state_t  ss;
    ss_state_t  next_ss;
    logic [15:0] rate_cnt;
    logic [15:0] next_rate_cnt;
    logic [4:0]  tri_pos;
    logic [4:0]  next_tri_pos;
    logic        tri_up;
    logic        next_tri_up;
    logic [15:0] lfsr;
    logic [15:0] next_lfsr;
    logic        run;
    assign run = fractional_feedback_field_mode_i && ss_enable_i && (ss_spread_i != 5'h00);
    always_comb
    begin
        next_ss       = ss;
        next_rate_cnt = rate_cnt;
        next_tri_pos  = tri_pos;
        next_tri_up   = tri_up;
        next_lfsr     = lfsr;
        unique case (ss)
            SS_IDLE:
            begin
                next_rate_cnt = 16'h0000;
                next_tri_pos = 5'h00;
                next_tri_up  = 1'b1;
                if (run)
                    next_ss = SS_RUN;
            end
            SS_RUN:
            begin
                if (!run)
                    next_ss = SS_IDLE;
                else if (rate_cnt >= ss_rate_i)
                begin
                    next_rate_cnt = 16'h0000;
                    next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
                    if (tri_up)
                    begin
                        next_tri_pos = tri_pos + 5'h01;
                        next_tri_up  = (tri_pos != 5'h1E);
                    end
                    else
                    begin
                        next_tri_pos = tri_pos - 5'h01;
                        next_tri_up  = (tri_pos == 5'h01);
                    end
                end
                else
                    next_rate_cnt = rate_cnt + 16'h0001;
            end
        endcase
    end
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ss       <= SS_IDLE;
            rate_cnt <= 16'h0000;
            tri_pos  <= 5'h00;
            tri_up   <= 1'b1;
            lfsr     <= `LFSR_SEED;
        end
        else
        begin
            ss       <= next_ss;
            rate_cnt <= next_rate_cnt;
            tri_pos  <= next_tri_pos;
            tri_up   <= next_tri_up;
            lfsr     <= next_lfsr;
        end
    end

    // Full-scale deviation = fb * spread * 0.1% in 2^-24 units
    logic [4:0]  shape;
    logic [63:0] dev_full;
    logic [63:0] dev_pos;
    logic [63:0] nominal;
    logic [63:0] modded;
    assign shape = ss_noise_i ? lfsr[4:0] : tri_pos;
    assign nominal = {29'h0, feedback_divider_i, fractional_feedback_field_i};
    assign dev_full = (nominal * {59'h0, ss_spread_i} * 64'(`DEPTH_STEP_PPM))
                      / 64'(`PPM_FULL);
    assign dev_pos = (dev_full * {59'h0, shape}) / 64'h1F;
    always_comb
    begin
        modded = nominal;
        if (ss == SS_RUN)
        begin
            if (ss_down_i)
                modded = nominal - dev_pos;
            else
                modded = nominal + dev_pos - (dev_full >> 1);
        end
    end

    // Fraction accumulator; carry lengthens one feedback count
    logic [23:0] acc;
    logic [24:0] sum;
    logic [11:0] next_int;
    logic        next_carry;
    assign sum = {1'b0, acc} + {1'b0, modded[23:0]};
    always_comb
    begin
        next_carry = fractional_feedback_field_mode_i & sum[24];
        next_int = {1'b0, modded[34:24]} + {11'h0, next_carry};
        if (!fractional_feedback_field_mode_i)
            next_int = {1'b0, feedback_divider_i};
    end
    logic bad;
    assign bad = !(mode inside {FB_POST_VCO, FB_POST_DIV, FB_EXTERNAL})
                 || (mode == FB_EXTERNAL && (feedback_divider_i < `FEEDBACK_DIVIDER_EXT_MIN
                     || feedback_divider_i > `FEEDBACK_DIVIDER_EXT_MAX))
                 || (reference_divider_i == 6'h00);
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            acc           <= 24'h000000;
            fb_int_o      <= 12'h000;
            fb_fractional_feedback_field_o     <= 24'h000000;
            fb_carry_o    <= 1'b0;
            fb_sel_fbin_o <= 1'b0;
            cfg_error_o   <= 1'b0;
            ss_active_o   <= 1'b0;
        end
        else
        begin
            acc           <= fractional_feedback_field_mode_i ? sum[23:0] : 24'h000000;
            fb_int_o      <= next_int;
            fb_fractional_feedback_field_o     <= fractional_feedback_field_mode_i ? modded[23:0] : 24'h000000;
            fb_carry_o    <= next_carry;
            fb_sel_fbin_o <= (mode == FB_EXTERNAL) ? fbk : od[0].clk_out;
            cfg_error_o   <= bad;
            ss_active_o   <= (next_ss == SS_RUN);
        end
    end

    AST_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
        !lock |=> clk_out_o == 4'h0) else $error("output while unlocked");
    AST_SS_INT: assert property (@(posedge clk_i) disable iff (rst_i)
        !fractional_feedback_field_mode_i |=> !ss_active_o) else $error("spread in integer mode");
    AST_INT_DIV: assert property (@(posedge clk_i) disable iff (rst_i)
        !fractional_feedback_field_mode_i |=> fb_int_o == {1'b0, $past(feedback_divider_i)})
        else $error("integer divide wrong");
    AST_CARRY: assert property (@(posedge clk_i) disable iff (rst_i)
        fb_carry_o |-> $past(fractional_feedback_field_mode_i)) else $error("carry outside fractional");
    AST_RESTART: assert property (@(posedge clk_i) disable iff (rst_i)
        lock_rise |=> ##1 clk_out_o == 4'h0) else $error("no restart on lock");
    AST_EXT: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == FB_EXTERNAL && feedback_divider_i > `FEEDBACK_DIVIDER_EXT_MAX) |=> cfg_error_o)
        else $error("bad feedback not flagged");
    AST_PRE: assert property (@(posedge clk_i) disable iff (rst_i)
        step |=> !step ##1 step) else $error("prescale not four");
    AST_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        ss_spread_i == 5'h00 |=> !ss_active_o) else $error("spread zero active");
    AST_CASC: assert property (@(posedge clk_i) disable iff (rst_i)
        lock && cascade_i && !od[2].tick |=> $stable(od[3].clk_out))
        else $error("cascaded divider stepped alone");
    AST_DOWN: assert property (@(posedge clk_i) disable iff (rst_i)
        (ss == SS_RUN && ss_down_i) |-> modded <= nominal)
        else $error("down spread above nominal");
    AST_ACT: assert property (@(posedge clk_i) disable iff (rst_i)
        ss_active_o |-> $past(fractional_feedback_field_mode_i)) else $error("spread without fraction");
    COV_LOCK: cover property (@(posedge clk_i) lock_rise);
    COV_SS: cover property (@(posedge clk_i) ss_active_o && ss_noise_i);
    COV_CASC: cover property (@(posedge clk_i) cascade_i && od[3].tick);
    COV_EXT: cover property (@(posedge clk_i) mode == FB_EXTERNAL && fb_sel_fbin_o);
endmodule // pll_divider_and_spread_modulator

// ### sim/clock_load_model.sv
module clock_load_model
(
    input  wire logic out_zero_i,
    output logic      feedback_clock_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Board trace delay, off the clock grid; the design's sync flops absorb it
    initial feedback_clock_o = 1'b0;
    always @(out_zero_i)
    begin
        feedback_clock_o <= #3 out_zero_i;
    end
endmodule // clock_load_model

// ### sim/tb_top.sv
module tb_top
    import pll_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        lock_i = 1'b0;
    logic [2:0]  fb_mode_i = 3'h1;
    logic        fractional_feedback_field_mode_i = 1'b0;
    logic [5:0]  reference_divider_i = 6'h01;
    logic [10:0] feedback_divider_i = 11'h064;
    logic [23:0] fractional_feedback_field_i = 24'h000000;
    logic [27:0] output_divider_i = 28'h0204081;
    logic        cascade_i = 1'b0;
    logic        ss_enable_i = 1'b0;
    logic        ss_down_i = 1'b0;
    logic        ss_noise_i = 1'b0;
    logic [4:0]  ss_spread_i = 5'h00;
    logic [15:0] ss_rate_i = 16'h0000;
    logic        feedback_clock_input_i;
    logic [3:0]  clk_out_o;
    logic [11:0] fb_int_o;
    logic [23:0] fb_fractional_feedback_field_o;
    logic        fb_carry_o, fb_sel_fbin_o, cfg_error_o, ss_active_o;
    int          num_errors = 0;
    int          checks_done = 0;
    int          seed;
    always #10 clk_i = ~clk_i;
    pll_divider_and_spread_modulator pll_divider_and_spread_modulator_i
    (
        .clk_i(clk_i), .rst_i(rst_i), .lock_i(lock_i), .fb_mode_i(fb_mode_i),
        .fractional_feedback_field_mode_i(fractional_feedback_field_mode_i), .reference_divider_i(reference_divider_i),
        .feedback_divider_i(feedback_divider_i),
        .fractional_feedback_field_i(fractional_feedback_field_i),
        .output_divider_i(output_divider_i), .cascade_i(cascade_i),
        .ss_enable_i(ss_enable_i), .ss_down_i(ss_down_i), .ss_noise_i(ss_noise_i),
        .ss_spread_i(ss_spread_i), .ss_rate_i(ss_rate_i),
        .feedback_clock_input_i(feedback_clock_input_i), .clk_out_o(clk_out_o),
        .fb_int_o(fb_int_o), .fb_fractional_feedback_field_o(fb_fractional_feedback_field_o), .fb_carry_o(fb_carry_o),
        .fb_sel_fbin_o(fb_sel_fbin_o), .cfg_error_o(cfg_error_o),
        .ss_active_o(ss_active_o)
    );
    clock_load_model clock_load_model_i
    (
        .out_zero_i(clk_out_o[0]),
        .feedback_clock_o(feedback_clock_input_i)
    );
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    function automatic logic sig(input int i);
        return (i < 4) ? clk_out_o[i] : fb_sel_fbin_o;
    endfunction
    // Output period is four oscillator ticks per divider count
    function automatic int half_period(input int div);
        return 2 * div;
    endfunction
    // Cycles between two toggles; the first partial half period is skipped
    task automatic gap(input int i, output int g);
        logic p;
        cyc(1);
        p = sig(i);
        for (g = 0; sig(i) === p && g < 4000; g++) cyc(1);
        p = sig(i);
        for (g = 0; sig(i) === p && g < 4000; g++) cyc(1);
    endtask
    task automatic relock();
        int bad;
        bad = 0;
        lock_i = 1'b0;
        cyc(6);
        repeat (12)
        begin
            cyc(1);
            bad += (clk_out_o !== 4'h0);
        end
        check("gated outputs", 0, bad);
        lock_i = 1'b1;
    endtask
    task automatic t_div();
        int d[4];
        int g;
        int bad;
        for (int r = 0; r < 2; r++)
        begin
            foreach (d[k]) d[k] = (r == 0) ? ((k % 2) ? 127 : 1) : $urandom_range(127, 1);
            output_divider_i = {7'(d[3]), 7'(d[2]), 7'(d[1]), 7'(d[0])};
            relock();
            foreach (d[k])
            begin
                gap(k, g);
                check("output half period", half_period(d[k]), g);
            end
            output_divider_i = {4{7'(d[2])}};
            relock();
            bad = 0;
            repeat (16 * d[2] + 40)
            begin
                cyc(1);
                bad += !(clk_out_o === 4'h0 || clk_out_o === 4'hF);
            end
            check("outputs aligned", 0, bad);
        end
        d[2] = $urandom_range(15, 2);
        d[3] = $urandom_range(15, 2);
        output_divider_i = {7'(d[3]), 7'(d[2]), 14'h0081};
        cascade_i = 1'b1;
        relock();
        gap(2, g);
        check("third half period", half_period(d[2]), g);
        gap(3, g);
        check("cascaded half period", half_period(d[2] * d[3]), g);
        cascade_i = 1'b0;
    endtask
    task automatic t_mode();
        int g;
        for (int m = 0; m < 8; m++)
        begin
            fb_mode_i = 3'(m);
            cyc(3);
            check("mode error", !(m == 1 || m == 2 || m == 4), cfg_error_o);
        end
        fb_mode_i = FB_POST_DIV;
        reference_divider_i = 6'h00;
        cyc(3);
        check("zero reference divider", 1, cfg_error_o);
        reference_divider_i = 6'h02;
        fb_mode_i = FB_EXTERNAL;
        feedback_divider_i = 11'd1;
        cyc(3);
        check("external low divider", 0, cfg_error_o);
        feedback_divider_i = 11'd1250;
        cyc(3);
        check("external high divider", 0, cfg_error_o);
        feedback_divider_i = 11'd1251;
        cyc(3);
        check("external over range", 1, cfg_error_o);
        feedback_divider_i = 11'd0;
        cyc(3);
        check("external zero divider", 1, cfg_error_o);
        output_divider_i = {21'h0, 7'($urandom_range(40, 1))};
        relock();
        gap(4, g);
        check("fed back half period", half_period(output_divider_i[6:0]), g);
        fb_mode_i = FB_POST_VCO;
    endtask
    task automatic t_fractional_feedback_field();
        int c;
        int n;
        longint e;
        feedback_divider_i = 11'($urandom_range(200, 32));
        cyc(3);
        check("integer divide", feedback_divider_i, {fb_carry_o, fb_int_o});
        fractional_feedback_field_mode_i = 1'b1;
        for (int r = 0; r < 2; r++)
        begin
            fractional_feedback_field_i = r ? 24'($urandom_range(24'hFFFFFF, 1)) : 24'h800000;
            cyc(4);
            check("fraction passed", fractional_feedback_field_i, fb_fractional_feedback_field_o);
            c = 0;
            n = 0;
            repeat (256)
            begin
                cyc(1);
                c += (fb_int_o === feedback_divider_i + 12'h001);
                n += fb_carry_o;
            end
            e = (longint'(fractional_feedback_field_i) * 256) >> 24;
            check("extra counts", 1, c == e || c == e + 1);
            check("carry pulses", 1, n <= c + 1 && c <= n + 1);
        end
    endtask
    task automatic t_spread();
        int mn;
        int mx;
        int s;
        feedback_divider_i = 11'd1000;
        fractional_feedback_field_i = 24'h000000;
        ss_enable_i = 1'b1;
        for (int t = 0; t < 8; t++)
        begin
            s = t[2] ? 10 : 31;
            {ss_spread_i, ss_down_i, ss_noise_i} = {5'(s), t[1], t[0]};
            cyc(4);
            check("modulator on", 1, ss_active_o);
            mn = 4095;
            mx = 0;
            repeat (400)
            begin
                cyc(1);
                mn = (fb_int_o < mn) ? fb_int_o : mn;
                mx = (fb_int_o > mx) ? fb_int_o : mx;
            end
            if (t[1])
                check("down span", 1, mx <= 1001 && mn >= 999 - s && mn < 1000);
            else
                check("center span", 1, mn >= 999 - s / 2 && mx <= 1001 + s / 2 && mn < 1000
                      && mx > 1000);
        end
        // Whole-unit down sweep: no carry, so every step shows on the integer
        ss_rate_i = 16'($urandom_range(7, 1));
        {ss_spread_i, ss_down_i, ss_noise_i} = {5'h1F, 2'b10};
        cyc(4);
        mn = 0;
        mx = fb_int_o;
        repeat (200)
        begin
            cyc(1);
            mn += (fb_int_o !== 12'(mx));
            mx = fb_int_o;
        end
        s = 200 / (ss_rate_i + 1);
        check("slow sweep steps", 1, mn == s || mn == s + 1);
        ss_spread_i = 5'h00;
        cyc(4);
        check("zero depth off", 0, ss_active_o);
        ss_spread_i = 5'h1F;
        fractional_feedback_field_mode_i = 1'b0;
        cyc(4);
        check("integer mode off", 0, ss_active_o);
        check("integer unmodulated", 1000, fb_int_o);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Generous bound: all tests together need at most about 11000 cycles
    initial
    begin
        cyc(90000);
        num_errors++;
        print_verdict();
    end
    initial
    begin
        seed = $urandom(32'h50FF);
        cyc(3);
        check("outputs in reset", 0, |{clk_out_o, fb_int_o, fb_fractional_feedback_field_o, fb_carry_o, cfg_error_o});
        cyc(1);
        rst_i = 1'b0;
        t_div();
        $display("test dividers done");
        t_mode();
        $display("test modes done");
        t_fractional_feedback_field();
        $display("test fraction done");
        t_spread();
        $display("test spread done");
        print_verdict();
    end
endmodule // tb_top
